/* bench/timer0_counter_prescaler_monitor.sv */
`timescale 1ns/10ps
module timer0_counter_prescaler_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic watchdog_tick,
  input wire logic overflow_irq,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable;
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no pready");
  property p_err; pslverr |-> acc; endproperty
  a_err: assert property (p_err) else $error("stray pslverr");
  property p_unm; acc && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_up; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_up: assert property (p_up) else $error("upper bits set");
  property p_map; acc && paddr == tmr_pkg::count_off |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("count access refused");
  property p_wd_gap; watchdog_tick |=> !watchdog_tick [*3]; endproperty
  a_wd_gap: assert property (p_wd_gap) else $error("watchdog ticks too close");
  property p_ovf; $fell(overflow_irq)
    |-> $past(acc && pwrite && paddr == tmr_pkg::intctl_off); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow irq cleared itself");
  property p_irq; $fell(irq) |-> $past(acc && (paddr == tmr_pkg::irq_status_off
    || paddr == tmr_pkg::irq_mask_off)); endproperty
  a_irq: assert property (p_irq) else $error("irq fell without access");
endmodule // timer0_counter_prescaler_monitor
bind timer0_counter_prescaler timer0_counter_prescaler_monitor u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .watchdog_tick(watchdog_tick),
  .overflow_irq(overflow_irq), .irq(irq));

/* bench/timer0_counter_prescaler_tb.sv */
`timescale 1ns/10ps
module timer0_counter_prescaler_tb;
  localparam logic [7:0] ca = tmr_pkg::count_off, oa = tmr_pkg::option_off;
  localparam logic [7:0] ia = tmr_pkg::intctl_off, ma = tmr_pkg::irq_mask_off;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pin = 1'h0, slp = 1'h0, pready, pslverr, oirq, irq, err, wd_tick;
  logic lv_q[$];
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  int miscompares = 0, n_compared = 0, cyc = 0, n, n_wd = 0;
  integer seed = 32'h6058;
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (cyc++ == 5000) finish_test(1);
  // Watchdog pulses seen at each edge
  always @(posedge pclk) if (wd_tick === 1'h1) n_wd <= n_wd + 1;
  timer0_counter_prescaler u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_input(pin), .sleep(slp),
    .watchdog_tick(wd_tick), .overflow_irq(oirq), .irq(irq));
  task finish_test(input int t);
    miscompares += t;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    miscompares += (g !== e);
    if (g !== e) $display("Error at %0t got %h expected %h", $time, g, e);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Two count reads k clocks apart; model: one tick per instruction cycle, divided
  task span(input int k, input int tdiv, input int wdiv);
    int w;
    bus(1'h0, ca, 8'h00);
    v = rd;
    w = n_wd;
    repeat (k - 3) @(posedge pclk);
    bus(1'h0, ca, 8'h00);
    chk((rd - v) & 32'hFF, tdiv ? k / tmr_pkg::icyc_div / tdiv : 0);
    chk(n_wd - w, wdiv ? k / tmr_pkg::icyc_div / wdiv : 0);
  endtask
  // Model of counter mode: qualifying edges in the recorded pin levels
  function automatic int edges(input bit falling);
    int c;
    c = 0;
    for (int i = 1; i < lv_q.size(); i++)
      c += falling ? (lv_q[i - 1] && !lv_q[i]) : (!lv_q[i - 1] && lv_q[i]);
    return c;
  endfunction
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    bus(1'h0, oa, 8'h00);
    chk(rd, {24'h0, tmr_pkg::option_rst});
    bus(1'h0, 8'h14, 8'h00);
    chk({rd[30:0], err}, 32'h1);
    $display("bus test done");
    bus(1'h1, oa, 8'h08);
    span(40, 1, 2);
    slp <= 1'h1;
    span(40, 0, 0);
    slp <= 1'h0;
    for (int r = 0; r < 3; r++)
    begin
      bus(1'h1, oa, 8'(r));
      span(24 << r, 2 << r, 1);
    end
    $display("timer test done");
    bus(1'h1, ia, 8'h00);
    bus(1'h1, ma, 8'h01);
    bus(1'h1, oa, 8'h08);
    bus(1'h1, ca, 8'hFE);
    repeat (4) @(posedge pclk);
    bus(1'h0, ca, 8'h00);
    chk(rd, 32'hFE);
    repeat (30) @(posedge pclk);
    chk({oirq, irq}, 32'h1);
    bus(1'h0, ia, 8'h00);
    chk(rd & 32'h4, 32'h4);
    bus(1'h1, ma, 8'h00);
    @(posedge pclk);
    chk({oirq, irq}, 32'h0);
    bus(1'h0, tmr_pkg::irq_status_off, 8'h00);
    chk(rd & 32'h3, 32'h3);
    bus(1'h1, ia, 8'hA4);
    @(posedge pclk);
    chk({oirq, irq}, 32'h2);
    bus(1'h1, ia, 8'hA0);
    @(posedge pclk);
    chk({oirq, irq}, 32'h0);
    $display("interrupt test done");
    for (int e = 0; e < 2; e++)
    begin
      pin <= 1'h0;
      lv_q.delete();
      lv_q.push_back(1'h0);
      bus(1'h1, oa, e ? 8'h38 : 8'h28);
      bus(1'h1, ca, 8'h00);
      n = $random(seed) & 7;
      repeat (2 * n + 1)
      begin
        repeat (16) @(posedge pclk);
        pin <= ~pin;
        lv_q.push_back(~lv_q[$]);
      end
      repeat (8) @(posedge pclk);
      bus(1'h0, ca, 8'h00);
      chk(rd, edges(e != 0));
    end
    $display("counter test done");
    finish_test(0);
  end
endmodule // timer0_counter_prescaler_tb

/* hw/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
  parameter int div = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire logic run,
  tick_if.src t
);
  // Divider register is 8 bits wide
  if (div < 1 || div > 256)
  begin : g_bad_div
    $error("div must lie between 1 and 256");
  end
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic [7:0] div_r;
  logic div_end;
  assign div_end = (div_r == 8'(div - 1));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      div_r <= 8'h00;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      div_r <= (div_end || !run) ? 8'h00 : div_r + 8'h01;
    end
  end
  // Edge detect on synchronised copy only
  assign t.rise = run && s2_r && !s3_r;
  assign t.fall = run && !s2_r && s3_r;
  assign t.tick = run && div_end;
endmodule // pin_sync

/* hw/tick_if.sv */
`timescale 1ns/10ps
interface tick_if;
  logic tick;
  logic rise;
  logic fall;
  modport src (output tick, output rise, output fall);
  modport dst (input tick, input rise, input fall);
endinterface

/* hw/timer0_counter_prescaler.sv */
`timescale 1ns/10ps
// Operation
// - 8-bit count, interrupt on FF to 00
// - Source select clear uses instruction clock
// - No prescaler: count every instruction cycle
// - Count write inhibits two instruction cycles
// - Source select set counts pin edges
// - Edge select: clear rising, set falling
// - Prescaler goes to timer or watchdog only
// - Prescaler count hidden from software
// - 8-bit programmable prescaler divides source
// - Overflow sets flag bit 2, enable bit 5
// - Timer stopped during sleep
// - Flag sets regardless of enables
module timer0_counter_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  input wire logic sleep,
  output logic watchdog_tick,
  output logic overflow_irq,
  output logic irq
);
  tick_if tk ();
  logic [7:0] timer_count_register_r;
  logic [7:0] option_r;
  logic [7:0] intctl_r;
  logic [7:0] prescale_r;
  logic [1:0] inhibit_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;
  logic [31:0] prdata_r;
  logic running;
  assign running = !sleep;
  pin_sync #(.div(tmr_pkg::icyc_div)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(external_count_input),
    .run(running),
    .t(tk.src)
  );
  logic wr;
  logic rd;
  logic wr_count;
  logic wr_option;
  logic wr_intctl;
  logic wr_mask;
  logic rd_status;
  logic mapped;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign wr_count = wr && (paddr == tmr_pkg::count_off);
  assign wr_option = wr && (paddr == tmr_pkg::option_off);
  assign wr_intctl = wr && (paddr == tmr_pkg::intctl_off);
  assign wr_mask = wr && (paddr == tmr_pkg::irq_mask_off);
  assign rd_status = rd && (paddr == tmr_pkg::irq_status_off);
  assign mapped = (paddr == tmr_pkg::count_off) || (paddr == tmr_pkg::option_off)
    || (paddr == tmr_pkg::intctl_off) || (paddr == tmr_pkg::irq_status_off)
    || (paddr == tmr_pkg::irq_mask_off);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;
  logic src_ext;
  logic edge_fall;
  logic ps_to_watchdog;
  logic [2:0] ps_rate;
  assign src_ext = option_r[tmr_pkg::src_sel_bit];
  assign edge_fall = option_r[tmr_pkg::edge_sel_bit];
  assign ps_to_watchdog = option_r[tmr_pkg::ps_assign_bit];
  assign ps_rate = option_r[tmr_pkg::ps_rate_lsb +: 3];
  // Selected source event
  logic src_ev;
  assign src_ev = src_ext ? (edge_fall ? tk.fall : tk.rise) : tk.tick;
  // Prescaler: tap of an 8-bit ripple count, ratio 2^(rate+1)
  logic [7:0] ps_inc;
  logic [7:0] ps_mask;
  logic ps_out;
  assign ps_inc = prescale_r + 8'h01;
  assign ps_mask = 8'((9'h002 << ps_rate) - 9'h001);
  assign ps_out = src_ev && ((prescale_r & ps_mask) == ps_mask);
  // Watchdog gets prescaled or raw instruction ticks, never shared
  assign watchdog_tick = ps_to_watchdog ? (tk.tick && ((prescale_r & ps_mask) == ps_mask))
    : tk.tick;
  logic ps_src_ev;
  assign ps_src_ev = ps_to_watchdog ? tk.tick : src_ev;
  logic tmr_ev;
  assign tmr_ev = ps_to_watchdog ? src_ev : ps_out;
  logic inhibit_tick;
  assign inhibit_tick = tk.tick && (inhibit_r != 2'b00);
  logic do_inc;
  assign do_inc = running && tmr_ev && (inhibit_r == 2'b00) && !wr_count;
  logic ovf;
  assign ovf = do_inc && (timer_count_register_r == 8'hFF);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_count_register_r <= tmr_pkg::count_rst;
      prescale_r <= 8'h00;
      inhibit_r <= 2'b00;
    end
    else
    begin
      if (wr_count)
      begin
        timer_count_register_r <= pwdata[7:0];
        inhibit_r <= 2'(tmr_pkg::write_inhibit_cycles);
      end
      else
      begin
        if (do_inc)
          timer_count_register_r <= timer_count_register_r + 8'h01;
        if (inhibit_tick)
          inhibit_r <= inhibit_r - 2'b01;
      end
      if (wr_count && !ps_to_watchdog)
        prescale_r <= 8'h00;
      else if (running && ps_src_ev)
        prescale_r <= ps_inc;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      option_r <= tmr_pkg::option_rst;
      irq_mask_r <= 2'b00;
    end
    else
    begin
      if (wr_option)
        option_r <= pwdata[7:0];
      if (wr_mask)
        irq_mask_r <= pwdata[1:0];
    end
  end
  // Interrupt control: flag set wins over software clear
  logic [7:0] intctl_nxt;
  assign intctl_nxt = wr_intctl ? pwdata[7:0] : intctl_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      intctl_r <= tmr_pkg::intctl_rst;
    else
    begin
      intctl_r <= intctl_nxt;
      if (ovf)
        intctl_r[tmr_pkg::ovf_flag_bit] <= 1'b1;
    end
  end
  // Sticky status: bit0 overflow, bit1 count write; read clears, set wins
  logic [1:0] ev;
  assign ev = {wr_count, ovf};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_r <= 2'b00;
    else
      irq_status_r <= (rd_status ? 2'b00 : irq_status_r) | ev;
  end
  assign overflow_irq = intctl_r[tmr_pkg::ovf_flag_bit] && intctl_r[tmr_pkg::ovf_en_bit]
    && intctl_r[tmr_pkg::global_enable_bit];
  assign irq = |(irq_status_r & irq_mask_r);
  // Read mux; prescaler count has no address
  logic [31:0] rd_mux;
  assign rd_mux = (paddr == tmr_pkg::count_off) ? {24'h000000, timer_count_register_r}
    : (paddr == tmr_pkg::option_off) ? {24'h000000, option_r}
    : (paddr == tmr_pkg::intctl_off) ? {24'h000000, intctl_r}
    : (paddr == tmr_pkg::irq_status_off) ? {30'h0000000, irq_status_r}
    : (paddr == tmr_pkg::irq_mask_off) ? {30'h0000000, irq_mask_r}
    : 32'h00000000;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata_r <= rd_mux;
  end
endmodule // timer0_counter_prescaler

/* hw/tmr_pkg.sv */
package tmr_pkg;
  // Register byte offsets
  localparam logic [7:0] count_off = 8'h00;
  localparam logic [7:0] option_off = 8'h04;
  localparam logic [7:0] intctl_off = 8'h08;
  localparam logic [7:0] irq_status_off = 8'h0C;
  localparam logic [7:0] irq_mask_off = 8'h10;
  // Option field positions
  localparam int ps_rate_lsb = 0;
  localparam int ps_assign_bit = 3;
  localparam int edge_sel_bit = 4;
  localparam int src_sel_bit = 5;
  // Interrupt control field positions
  localparam int ovf_flag_bit = 2;
  localparam int ovf_en_bit = 5;
  localparam int global_enable_bit = 7;
  // Reset values
  localparam logic [7:0] option_rst = 8'hFF;
  localparam logic [7:0] intctl_rst = 8'h00;
  localparam logic [7:0] count_rst = 8'h00;
  // Cycles of inhibit after a count write
  localparam int write_inhibit_cycles = 2;
  // Instruction cycle = 4 clocks
  localparam int icyc_div = 4;
endpackage
